/* File: rtl/gsc_pkg.sv */
// Purpose: Constants and types for the gated/signed edge counter channel
// Assumes: One 40 MHz clock, asynchronous active-low reset
// Notes: Register map offsets are word addresses on the plain register port
`default_nettype none

package gsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] GSC_OFS_CTRL = 4'h0;
    localparam logic [3:0] GSC_OFS_FILT_PRI = 4'h1;
    localparam logic [3:0] GSC_OFS_FILT_SEC = 4'h2;
    localparam logic [3:0] GSC_OFS_COUNT = 4'h3;
    localparam logic [3:0] GSC_OFS_STATUS = 4'h4;
    localparam logic [3:0] GSC_OFS_IRQ_EN = 4'h5;
    localparam logic [3:0] GSC_OFS_IRQ_CLR = 4'h6;
    localparam logic [3:0] GSC_OFS_DMA_SEL0 = 4'h7;
    localparam logic [3:0] GSC_OFS_DMA_SEL1 = 4'h8;
    localparam logic [3:0] GSC_OFS_INPUTS = 4'h9;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int GSC_MODE_LSB = 0;
    localparam int GSC_FILT_EN_BIT = 3;
    localparam int GSC_DMA_EN_BIT = 4;
    localparam int GSC_PER_LSB = 0;
    localparam int GSC_CNT_LSB = 8;
    localparam int GSC_NUM_DMA = 2;
    localparam int GSC_NUM_EVT = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] GSC_CTRL_RST = 16'h0000;
    localparam logic [15:0] GSC_FILT_RST = 16'h0000;
    localparam logic [15:0] GSC_COUNT_RST = 16'h0000;
    localparam logic [1:0] GSC_DMA_SEL_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing: filter pipeline (latency 5 at count 0)
    // ------------------------------------------------------------
    localparam int GSC_FILT_BASE_LAT = 5;
    localparam int GSC_FILT_SYNC_STAGES = 2;

    // Count modes of the count_mode_field
    typedef enum logic [2:0] {
        GSC_MODE_STOP = 3'b000,
        GSC_MODE_GATED = 3'b011,
        GSC_MODE_SIGNED = 3'b101
    } gsc_mode_type;

    // Event indices shared by status and DMA selectors
    localparam int GSC_EVT_COUNT = 0;
    localparam int GSC_EVT_UP = 1;
    localparam int GSC_EVT_DOWN = 2;
    localparam int GSC_EVT_WRAP = 3;

    typedef struct packed {
        logic [7:0] filter_sample_count;
        logic [7:0] filter_sample_period;
    } gsc_filt_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gsc_bus_type;

endpackage : gsc_pkg

`default_nettype wire

/* File: rtl/gsc_filter.sv */
// Purpose: Input filter, fixed base latency plus glitch qualification
// Assumes: Input synchronous to clk
// Notes: Period 0 samples every clock; enable low bypasses the filter (pipeline only)
`default_nettype none

module gsc_filter
    import gsc_pkg::*;
(
    input wire logic clk,                // Module clock
    input wire logic reset_n,            // Async reset, active low
    input wire logic enable,             // Filter in use
    input wire gsc_filt_type cfg,        // Period and count
    input wire logic sig_in,             // Raw input
    output logic sig_out                 // Filtered input
);

    logic [GSC_FILT_SYNC_STAGES-1:0] sync_reg;
    logic [7:0] per_reg;
    logic [8:0] agree_reg;
    logic cand_reg;
    logic held_reg;
    logic [1:0] out_pipe_reg;
    // Reload on a shortened period so a new setting ticks at once
    wire logic tick = (per_reg == 8'h00) || (per_reg >= cfg.filter_sample_period);
    wire logic smp = sync_reg[GSC_FILT_SYNC_STAGES-1];
    wire logic [8:0] need = {1'b0, cfg.filter_sample_count};
    // Run of agreeing samples including the live one; saturates, never wraps
    wire logic [8:0] run = (smp != cand_reg) ? 9'h000
                         : (agree_reg == 9'h1FF) ? agree_reg : agree_reg + 9'h001;
    // Qualify on the live sample so count 0 adds a single stage
    wire logic take = tick && (run >= need);
    wire logic out_src = enable ? held_reg : smp;

    // ------------------------------------------------------------
    // Sample, qualify over count+1 agreeing samples
    // ------------------------------------------------------------
    // Two sync stages + held + two output stages give 5 cycles at count 0
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_reg <= '0;
            per_reg <= 8'h00;
            agree_reg <= 9'h000;
            cand_reg <= 1'b0;
            held_reg <= 1'b0;
            out_pipe_reg <= 2'b00;
        end
        else
        begin
            sync_reg <= {sync_reg[GSC_FILT_SYNC_STAGES-2:0], sig_in};
            per_reg <= tick ? (cfg.filter_sample_period - 8'h01) : (per_reg - 8'h01);
            if (tick)
            begin
                cand_reg <= smp;
                agree_reg <= run;
            end
            if (take)
                held_reg <= smp;
            out_pipe_reg <= {out_pipe_reg[0], out_src};
        end
    end

    assign sig_out = out_pipe_reg[1];

endmodule : gsc_filter

`default_nettype wire

/* File: rtl/gsc_dma_sel.sv */
// Purpose: One DMA request line picked from the event vector
// Assumes: Events are one-cycle pulses
// Notes: Equal selectors drive several lines from one event
`default_nettype none

module gsc_dma_sel
    import gsc_pkg::*;
(
    input wire logic clk,                      // Module clock
    input wire logic reset_n,                  // Async reset, active low
    input wire logic enable,                   // DMA requests enabled
    input wire logic [1:0] select,             // Event selector
    input wire logic [GSC_NUM_EVT-1:0] events, // Event pulses
    output logic req                           // DMA request pulse
);

    logic req_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            req_reg <= 1'b0;
        else
            req_reg <= enable && events[select];
    end

    assign req = req_reg;

endmodule : gsc_dma_sel

`default_nettype wire

/* File: rtl/gsc_counter.sv */
// Purpose: Gated/signed edge counter channel with filters, IRQ and DMA
// Assumes: Inputs synchronous to clk; register port one-cycle strobes
// Notes: Primary edge is compared with the secondary level of the same
//        sample, so the one-cycle skew hazard of older designs is absent
`default_nettype none

module gsc_counter
    import gsc_pkg::*;
(
    input wire logic clk,                         // 40 MHz module clock
    input wire logic reset_n,                     // Async reset, active low
    input wire logic primary_in,                  // Primary count input
    input wire logic secondary_in,                // Secondary gate/direction
    input wire logic [3:0] reg_addr,              // Register address
    input wire logic [15:0] reg_wdata,            // Write data
    input wire logic reg_wr,                      // Write strobe
    input wire logic reg_rd,                      // Read strobe
    output logic [15:0] reg_rdata,                // Read data, cycle after rd
    output logic irq,                             // Level interrupt
    output logic [GSC_NUM_DMA-1:0] dma_req        // DMA request pulses
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    gsc_filt_type filt_pri_reg;
    gsc_filt_type filt_sec_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [GSC_NUM_EVT-1:0] status_reg;
    logic [GSC_NUM_EVT-1:0] irq_en_reg;
    logic [1:0] dma_sel_reg [GSC_NUM_DMA];
    logic [15:0] rdata_reg;
    logic pri_q_reg;
    logic sec_q_reg;

    gsc_bus_type bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    function automatic logic hit(input gsc_bus_type b, input logic [3:0] ofs);
        hit = b.addr == ofs;
    endfunction : hit

    wire logic wr_ctrl = bus.wr && hit(bus, GSC_OFS_CTRL);
    wire logic wr_fpri = bus.wr && hit(bus, GSC_OFS_FILT_PRI);
    wire logic wr_fsec = bus.wr && hit(bus, GSC_OFS_FILT_SEC);
    wire logic wr_count = bus.wr && hit(bus, GSC_OFS_COUNT);
    wire logic wr_ien = bus.wr && hit(bus, GSC_OFS_IRQ_EN);
    wire logic wr_iclr = bus.wr && hit(bus, GSC_OFS_IRQ_CLR);

    gsc_mode_type mode;
    assign mode = gsc_mode_type'(ctrl_reg[GSC_MODE_LSB +: 3]);
    wire logic filt_en = ctrl_reg[GSC_FILT_EN_BIT];
    wire logic dma_en = ctrl_reg[GSC_DMA_EN_BIT];

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    logic pri_f;
    logic sec_f;

    gsc_filter u_filt_pri (
        .clk(clk),
        .reset_n(reset_n),
        .enable(filt_en),
        .cfg(filt_pri_reg),
        .sig_in(primary_in),
        .sig_out(pri_f)
    );

    gsc_filter u_filt_sec (
        .clk(clk),
        .reset_n(reset_n),
        .enable(filt_en),
        .cfg(filt_sec_reg),
        .sig_in(secondary_in),
        .sig_out(sec_f)
    );

    // One sample per clock, so at most one edge per input per period
    wire logic pri_rise = pri_f && !pri_q_reg;
    wire logic sec_rise = sec_f && !sec_q_reg;

    // Secondary level taken from the same sample as the primary edge
    wire logic gated_inc = (pri_rise && sec_f)
                         || (sec_rise && pri_f && !pri_rise);
    wire logic signed_up = pri_rise && sec_f;
    wire logic signed_dn = pri_rise && !sec_f;

    wire logic do_up = (mode == GSC_MODE_GATED) ? gated_inc
                     : (mode == GSC_MODE_SIGNED) ? signed_up : 1'b0;
    wire logic do_dn = (mode == GSC_MODE_SIGNED) ? signed_dn : 1'b0;

    always_comb
    begin
        count_next = count_reg;
        if (wr_count)
            count_next = bus.wdata;
        else if (do_up)
            count_next = count_reg + 16'h0001;
        else if (do_dn)
            count_next = count_reg - 16'h0001;
    end

    wire logic wrap = !wr_count && ((do_up && count_reg == 16'hFFFF)
                                 || (do_dn && count_reg == 16'h0000));

    logic [GSC_NUM_EVT-1:0] events;
    assign events[GSC_EVT_COUNT] = do_up || do_dn;
    assign events[GSC_EVT_UP] = do_up;
    assign events[GSC_EVT_DOWN] = do_dn;
    assign events[GSC_EVT_WRAP] = wrap;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= GSC_CTRL_RST;
            filt_pri_reg <= GSC_FILT_RST;
            filt_sec_reg <= GSC_FILT_RST;
            count_reg <= GSC_COUNT_RST;
            irq_en_reg <= '0;
            pri_q_reg <= 1'b0;
            sec_q_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= bus.wdata;
            if (wr_fpri)
                filt_pri_reg <= bus.wdata;
            if (wr_fsec)
                filt_sec_reg <= bus.wdata;
            if (wr_ien)
                irq_en_reg <= bus.wdata[GSC_NUM_EVT-1:0];
            count_reg <= count_next;
            pri_q_reg <= pri_f;
            sec_q_reg <= sec_f;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            status_reg <= '0;
        else
            status_reg <= (status_reg & ~(wr_iclr ? bus.wdata[GSC_NUM_EVT-1:0] : '0))
                        | events;
    end

    // ------------------------------------------------------------
    // DMA request selectors
    // ------------------------------------------------------------
    // Distinct selectors are software's job; duplicates fan out
    generate
        for (genvar i = 0; i < GSC_NUM_DMA; i++)
        begin : g_dma
            localparam logic [3:0] SEL_OFS = GSC_OFS_DMA_SEL0 + 4'(i);
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    dma_sel_reg[i] <= GSC_DMA_SEL_RST;
                else if (bus.wr && hit(bus, SEL_OFS))
                    dma_sel_reg[i] <= bus.wdata[1:0];
            end
            gsc_dma_sel u_sel (
                .clk(clk),
                .reset_n(reset_n),
                .enable(dma_en),
                .select(dma_sel_reg[i]),
                .events(events),
                .req(dma_req[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb
    begin
        unique case (bus.addr)
            GSC_OFS_CTRL: rd_mux = ctrl_reg;
            GSC_OFS_FILT_PRI: rd_mux = filt_pri_reg;
            GSC_OFS_FILT_SEC: rd_mux = filt_sec_reg;
            GSC_OFS_COUNT: rd_mux = count_reg;
            GSC_OFS_STATUS: rd_mux = {12'h000, status_reg};
            GSC_OFS_IRQ_EN: rd_mux = {12'h000, irq_en_reg};
            GSC_OFS_DMA_SEL0: rd_mux = {14'h0000, dma_sel_reg[0]};
            GSC_OFS_DMA_SEL1: rd_mux = {14'h0000, dma_sel_reg[1]};
            GSC_OFS_INPUTS: rd_mux = {14'h0000, sec_f, pri_f};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_reg <= 16'h0000;
        else
            rdata_reg <= bus.rd ? rd_mux : 16'h0000;
    end

    assign reg_rdata = rdata_reg;
    assign irq = |(status_reg & irq_en_reg);

endmodule : gsc_counter

`default_nettype wire

/* File: dv/gsc_counter_chk.sv */
// Purpose: Port-level assertions for the edge counter
// Assumes: Sees only the ports of gsc_counter
// Notes: Mirrors of written registers stand in for hidden state
`default_nettype none

module gsc_counter_chk
    import gsc_pkg::*;
(
    input wire logic clk, // Module clock
    input wire logic reset_n, // Reset, active low
    input wire logic primary_in, // Primary input
    input wire logic secondary_in, // Secondary input
    input wire logic [3:0] reg_addr, // Address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [15:0] reg_rdata, // Read data
    input wire logic irq, // Interrupt
    input wire logic [GSC_NUM_DMA-1:0] dma_req // DMA pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Register mirrors
    // ----
    logic [4:0] ctrl_reg;
    logic [1:0] sel0_reg;
    logic [1:0] sel1_reg;
    logic [2:0] age_reg;
    wire logic wr_ctrl = reg_wr && reg_addr == GSC_OFS_CTRL;
    wire logic wr_sel0 = reg_wr && reg_addr == GSC_OFS_DMA_SEL0;
    wire logic wr_sel1 = reg_wr && reg_addr == GSC_OFS_DMA_SEL1;
    wire logic [4:0] ctrl_next = wr_ctrl ? reg_wdata[4:0] : ctrl_reg;
    wire logic [1:0] sel0_next = wr_sel0 ? reg_wdata[1:0] : sel0_reg;
    wire logic [1:0] sel1_next = wr_sel1 ? reg_wdata[1:0] : sel1_reg;
    // Pipeline still holds reset zeros for a few cycles
    wire logic [2:0] age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
    wire logic dma_on = ctrl_reg[GSC_DMA_EN_BIT];
    wire logic sel_same = sel0_reg == sel1_reg;
    wire logic stopped = ctrl_reg[2:0] == 3'b000;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= 5'h00;
            sel0_reg <= 2'h0;
            sel1_reg <= 2'h0;
            age_reg <= 3'h0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            sel0_reg <= sel0_next;
            sel1_reg <= sel1_next;
            age_reg <= age_next;
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_quiet;
        (age_reg == 3'h7 && !ctrl_reg[GSC_FILT_EN_BIT] && $stable(primary_in)
            && $stable(secondary_in))[*6];
    endsequence
    sequence s_load;
        reg_wr && reg_addr == GSC_OFS_COUNT && stopped;
    endsequence

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr > GSC_OFS_INPUTS |=> reg_rdata == 16'h0000;
    endproperty
    property p_clr_zero;
        reg_rd && reg_addr == GSC_OFS_IRQ_CLR |=> reg_rdata == 16'h0000;
    endproperty
    property p_irq_mask;
        reg_wr && reg_addr == GSC_OFS_IRQ_EN && reg_wdata[3:0] == 4'h0 |=> !irq;
    endproperty
    property p_dma_off;
        !dma_on && !$past(dma_on) |-> dma_req == {GSC_NUM_DMA{1'b0}};
    endproperty
    property p_dma_pair;
        sel_same && $past(sel_same) |-> dma_req[0] == dma_req[1];
    endproperty
    property p_inputs;
        s_quiet ##0 (reg_rd && reg_addr == GSC_OFS_INPUTS)
            |=> reg_rdata[1:0] == {$past(secondary_in), $past(primary_in)};
    endproperty
    property p_count_hold;
        s_load ##1 (reg_rd && reg_addr == GSC_OFS_COUNT && stopped)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_clr_zero: assert property (p_clr_zero)
        else $error("clear register read not zero");
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt stays high when masked");
    a_dma_off: assert property (p_dma_off)
        else $error("request while requests disabled");
    a_dma_pair: assert property (p_dma_pair)
        else $error("equal selectors gave unequal requests");
    a_inputs: assert property (p_inputs)
        else $error("sampled input levels wrong");
    a_count_hold: assert property (p_count_hold)
        else $error("count moved in stop mode");
endmodule : gsc_counter_chk

bind gsc_counter gsc_counter_chk u_chk (.clk, .reset_n, .primary_in, .secondary_in, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .dma_req);

`default_nettype wire

/* File: dv/gsc_src_model.sv */
// Purpose: Input sources and DMA sink beside the counter
// Assumes: Bench calls drive right after a clock edge
// Notes: Levels start at zero by blocking assignment, then change by non-blocking assignment only
`default_nettype none

module gsc_src_model
    import gsc_pkg::*;
(
    input wire logic clk, // Module clock
    input wire logic [GSC_NUM_DMA-1:0] dma_req, // DMA pulses
    output logic primary_in, // Primary source
    output logic secondary_in // Secondary source
);
    timeunit 1ns;
    timeprecision 1ps;
    int dma_seen[GSC_NUM_DMA];

    initial
    begin
        primary_in = 1'b0;
        secondary_in = 1'b0;
    end

    // Each pulse seen once, as a controller would take it
    always @(posedge clk)
    begin
        for (int i = 0; i < GSC_NUM_DMA; i++)
            dma_seen[i] += (dma_req[i] === 1'b1) ? 1 : 0;
    end

    // Caller keeps primary low ahead of a secondary rise unless probing it
    task automatic drive(input bit p, input bit s, input int n);
        primary_in <= p;
        secondary_in <= s;
        repeat (n) @(posedge clk);
    endtask : drive
endmodule : gsc_src_model

`default_nettype wire

/* File: dv/gsc_counter_bench.sv */
// Purpose: Self-checking bench for the edge counter
// Assumes: Step model mirrors the counting rules
// Notes: Each input step lasts at least one clock
`default_nettype none

module gsc_counter_bench
    import gsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset_n;
    logic primary_in;
    logic secondary_in;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic irq;
    logic [GSC_NUM_DMA-1:0] dma_req;
    int fail_count, comparisons, cycles;
    int cnt, st, ie, den, pm, sm;
    logic [2:0] md;
    int sel[2];
    int exp_dma[2];

    gsc_counter uut (.clk, .reset_n, .primary_in, .secondary_in, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .dma_req);
    gsc_src_model src (.clk, .dma_req, .primary_in, .secondary_in);

    always #12.5 clk = ~clk;

    // ----
    // Tasks
    // ----
    task automatic print_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic setup(input logic [15:0] c, input int s0, input int s1);
        wr(GSC_OFS_DMA_SEL0, 16'(s0));
        wr(GSC_OFS_DMA_SEL1, 16'(s1));
        wr(GSC_OFS_CTRL, c);
        md = c[2:0];
        den = int'(c[GSC_DMA_EN_BIT]);
        sel[0] = s0;
        sel[1] = s1;
    endtask : setup

    // Reference model works on whole steps, never on the pipeline
    task automatic step(input bit p, input bit s, input int n);
        int d;
        logic [3:0] evb;
        d = 0;
        if (md == GSC_MODE_GATED && ((p && !pm && s) || (s && !sm && p)))
            d = 1;
        if (md == GSC_MODE_SIGNED && p && !pm)
            d = s ? 1 : -1;
        cnt = (cnt + d) & 32'h0000_ffff;
        evb = (d == 0) ? 4'h0 : {(d > 0 && cnt == 0) || (d < 0 && cnt == 32'h0000_ffff),
            d < 0, d > 0, 1'b1};
        st |= evb;
        for (int i = 0; i < 2; i++)
            exp_dma[i] += (den != 0 && evb[sel[i]]) ? 1 : 0;
        pm = p;
        sm = s;
        src.drive(p, s, n);
    endtask : step

    task automatic check();
        logic [15:0] v;
        repeat (8) @(posedge clk);
        rd(GSC_OFS_COUNT, v);
        cmp("count", 16'(cnt), v);
        rd(GSC_OFS_STATUS, v);
        cmp("status", 16'(st), v);
        cmp("irq", 16'((st & ie) != 0), {15'h0000, irq});
        cmp("dma0", 16'(exp_dma[0]), 16'(src.dma_seen[0]));
        cmp("dma1", 16'(exp_dma[1]), 16'(src.dma_seen[1]));
    endtask : check

    task automatic poll(output int np, output int ns);
        logic [15:0] v;
        np = -1;
        ns = -1;
        src.drive(1'b1, 1'b1, 0);
        for (int i = 0; i < 16; i++)
        begin
            rd(GSC_OFS_INPUTS, v);
            if (v[0] && np < 0)
                np = i;
            if (v[1] && ns < 0)
                ns = i;
        end
        src.drive(1'b0, 1'b0, 12);
    endtask : poll

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ----
    // Main sequence
    // ----
    initial
    begin
        int n0p, n0s, np, ns;
        logic [15:0] v;
        logic [15:0] pat;
        clk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        md = GSC_MODE_STOP;
        void'($urandom(97));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        for (int a = 0; a < 16; a++)
        begin
            rd(4'(a), v);
            cmp("reset", 16'h0000, v);
        end
        wr(GSC_OFS_COUNT, 16'hffff);
        cnt = 32'h0000_ffff;
        rd(GSC_OFS_COUNT, v);
        cmp("load", 16'hffff, v);
        step(1'b1, 1'b0, 3);
        step(1'b0, 1'b0, 3);
        check();
        // Steps as {primary, secondary}, first pair highest
        pat = 16'h7b48;
        setup(16'h0013, 3, 0);
        for (int i = 7; i >= 0; i--)
            step(pat[2 * i + 1], pat[2 * i], 3);
        wr(GSC_OFS_IRQ_EN, 16'h000f);
        ie = 15;
        check();
        wr(GSC_OFS_IRQ_CLR, 16'hffff);
        st = 0;
        check();
        setup(16'h0015, 1, 2);
        wr(GSC_OFS_COUNT, 16'h0100);
        cnt = 32'h0000_0100;
        step(1'b1, 1'b0, 1);
        step(1'b1, 1'b1, 3);
        step(1'b0, 1'b0, 3);
        repeat (40) step(1'($urandom), 1'($urandom), 1 + int'($urandom % 3));
        check();
        setup(16'h0015, 0, 0);
        // Count down through zero to raise the wrap event
        wr(GSC_OFS_COUNT, 16'h0000);
        cnt = 0;
        step(1'b0, 1'b0, 2);
        step(1'b1, 1'b0, 2);
        repeat (20) step(1'($urandom), 1'($urandom), 1 + int'($urandom % 3));
        wr(GSC_OFS_IRQ_EN, 16'h0004);
        ie = 4;
        check();
        wr(GSC_OFS_IRQ_EN, 16'h0000);
        ie = 0;
        check();
        setup(16'h0000, 0, 1);
        step(1'b0, 1'b0, 8);
        poll(n0p, n0s);
        wr(GSC_OFS_FILT_PRI, 16'h0001);
        wr(GSC_OFS_FILT_SEC, 16'h0101);
        wr(GSC_OFS_CTRL, 16'h0008);
        poll(np, ns);
        cmp("pri_lat", 16'(n0p + 1), 16'(np));
        cmp("sec_lat", 16'(n0s + 2), 16'(ns));
        cmp("pri_abs", 16'(GSC_FILT_BASE_LAT), 16'(np));
        cmp("sec_abs", 16'(GSC_FILT_BASE_LAT + 1), 16'(ns));
        print_verdict();
    end
endmodule : gsc_counter_bench

`default_nettype wire
